/* hdl/rcs_reset_cause.sv */
// reset cause and register state logic with an apb register slave
// assumes all event inputs are synchronous to pclk; presetn is power-on
`timescale 1ns/1ps
`default_nettype none

module rcs_reset_cause
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset sources and core state
    input wire logic brownout_event,
    input wire logic watchdog_expire,
    input wire logic external_reset_pin_n,
    input wire logic core_sleep,
    input wire logic [7:0] wake_pins,
    // core side results
    output logic core_reset_pulse,
    output logic [10:0] pc_start,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic irq
);
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [4:0] idx;
    logic addr_ok;
    logic access;
    logic wr_fire;
    logic ext_n_prev_reg;
    logic ext_assert;
    logic wake_hit;
    logic soft_rst;
    rcs_pkg::rcs_cause_e cause;
    rcs_pkg::rcs_cause_e cause_reg;
    rcs_pkg::rcs_status_s status_reg;
    rcs_pkg::rcs_status_s status_wr;
    logic [1:0] flags_next;
    logic [7:0] counter_reg;
    logic [7:0] pc_low_reg;
    logic [7:0] pointer_reg;
    logic [7:0] cmp_reg;
    logic [7:0] working_reg;
    logic [7:0] port_data_reg;
    logic [7:0] wake_pending_reg;
    logic [7:0] pins_prev_reg;
    logic [7:0] wake_edge_hit;
    logic [7:0] cfg_reg [rcs_pkg::CFG_COUNT];
    logic [7:0] int_status_reg;
    logic [7:0] int_mask_reg;
    logic [7:0] int_events;
    logic core_reset_reg;
    logic [10:0] pc_start_reg;
    logic irq_reg;

    // word-aligned decode, low two address bits must be zero
    assign idx = paddr[6:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && !paddr[7];
    assign access = psel && penable;
    assign wr_fire = access && pready_reg && pwrite && addr_ok && rd_hit;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= rcs_pkg::APB_ZERO;
        end
        else if (access && !pready_reg)
        begin
            pready_reg <= 1'b1;
            pslverr_reg <= !(addr_ok && rd_hit);
            prdata_reg <= (pwrite || !addr_ok) ? rcs_pkg::APB_ZERO : rd_data;
        end
        else
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // reset source detection and priority
    assign ext_assert = ext_n_prev_reg && !external_reset_pin_n;
    assign wake_hit = core_sleep
        && |(wake_pending_reg & ~cfg_reg[rcs_pkg::CFG_WAKE_MASK]);
    assign soft_rst = brownout_event || ext_assert || watchdog_expire || wake_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_n_prev_reg <= 1'b1;
        end
        else
        begin
            ext_n_prev_reg <= external_reset_pin_n;
        end
    end

    // brown-out outranks the pin, the pin outranks the watchdog
    always_comb
    begin
        cause = rcs_pkg::RCS_WAKE;
        if (brownout_event)
        begin
            cause = rcs_pkg::RCS_BOR;
        end
        else if (ext_assert)
        begin
            cause = rcs_pkg::RCS_EXT;
        end
        else if (watchdog_expire)
        begin
            cause = rcs_pkg::RCS_WDT;
        end
    end

    // flag pair next value, ordered {timeout_flag, powerdown_flag}
    always_comb
    begin
        flags_next = {status_reg.timeout_flag, status_reg.powerdown_flag};
        case (cause)
            rcs_pkg::RCS_BOR:
                flags_next = 2'b11;
            rcs_pkg::RCS_EXT:
                if (core_sleep)
                begin
                    flags_next = 2'b10;
                end
                else
                begin
                    flags_next = {status_reg.timeout_flag, status_reg.powerdown_flag};
                end
            rcs_pkg::RCS_WDT:
                flags_next = core_sleep ? 2'b00 : 2'b01;
            rcs_pkg::RCS_WAKE:
                flags_next = 2'b10;
            default:
                flags_next = 2'b11;
        endcase
    end

    // software view of status: flags kept, other bits from the bus
    always_comb
    begin
        status_wr = rcs_pkg::rcs_status_s'(pwdata[7:0]);
        status_wr.timeout_flag = status_reg.timeout_flag;
        status_wr.powerdown_flag = status_reg.powerdown_flag;
    end

    // one register holds arithmetic, page and timeout/powerdown flag bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg.page <= rcs_pkg::PAGE_RESET;
            status_reg.timeout_flag <= 1'b1;
            status_reg.powerdown_flag <= 1'b1;
            status_reg.arith <= 3'h0;
        end
        else if (soft_rst)
        begin
            status_reg.page <= rcs_pkg::PAGE_RESET;
            status_reg.timeout_flag <= flags_next[1];
            status_reg.powerdown_flag <= flags_next[0];
        end
        else if (wr_fire && idx == rcs_pkg::IDX_STATUS)
        begin
            status_reg <= status_wr;
        end
    end

    // cause is kept readable for software beside the flag pair
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cause_reg <= rcs_pkg::RCS_POR;
        end
        else if (soft_rst)
        begin
            cause_reg <= cause;
        end
    end

    // start address and a one-cycle restart strobe toward the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reset_reg <= 1'b1;
            pc_start_reg <= rcs_pkg::PC_TOP;
        end
        else
        begin
            core_reset_reg <= soft_rst;
            pc_start_reg <= rcs_pkg::PC_TOP;
        end
    end

    // program counter low byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_low_reg <= rcs_pkg::PC_LOW_RESET;
        end
        else if (soft_rst)
        begin
            pc_low_reg <= rcs_pkg::PC_LOW_RESET;
        end
        else if (wr_fire && idx == rcs_pkg::IDX_PC_LOW)
        begin
            pc_low_reg <= pwdata[7:0];
        end
    end

    // configuration registers, all forced on any reset
    genvar gi;
    generate
        for (gi = 0; gi < rcs_pkg::CFG_COUNT; gi++)
        begin : g_cfg
            localparam logic [7:0] RST_VAL =
                (gi == rcs_pkg::CFG_MODE) ? rcs_pkg::MODE_RESET : rcs_pkg::CFG_RESET;
            localparam logic [4:0] MY_IDX = rcs_pkg::IDX_CFG_BASE + 5'(gi);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cfg_reg[gi] <= RST_VAL;
                end
                else if (soft_rst)
                begin
                    cfg_reg[gi] <= RST_VAL;
                end
                else if (wr_fire && idx == MY_IDX)
                begin
                    cfg_reg[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // free running counter; brown-out leaves it undefined, kept here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_reg <= rcs_pkg::BYTE_ZERO;
        end
        else if (wr_fire && idx == rcs_pkg::IDX_COUNTER)
        begin
            counter_reg <= pwdata[7:0];
        end
        else
        begin
            counter_reg <= counter_reg + rcs_pkg::BYTE_ONE;
        end
    end

    // indirect pointer: top bit forced, rest survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pointer_reg <= rcs_pkg::BYTE_ZERO;
        end
        else if (soft_rst)
        begin
            pointer_reg <= pointer_reg | rcs_pkg::POINTER_FORCE;
        end
        else if (wr_fire && idx == rcs_pkg::IDX_POINTER)
        begin
            pointer_reg <= pwdata[7:0];
        end
    end

    // comparator: three bits forced, the others survive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_reg <= rcs_pkg::CMP_FORCE;
        end
        else if (soft_rst)
        begin
            cmp_reg <= cmp_reg | rcs_pkg::CMP_FORCE;
        end
        else if (wr_fire && idx == rcs_pkg::IDX_COMPARATOR)
        begin
            cmp_reg <= pwdata[7:0];
        end
    end

    // working and port data registers ride through soft resets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            working_reg <= rcs_pkg::BYTE_ZERO;
            port_data_reg <= rcs_pkg::BYTE_ZERO;
        end
        else if (wr_fire && !brownout_event)
        begin
            if (idx == rcs_pkg::IDX_WORKING)
            begin
                working_reg <= pwdata[7:0];
            end
            if (idx == rcs_pkg::IDX_PORT_DATA)
            begin
                port_data_reg <= pwdata[7:0];
            end
        end
    end

    // wake edge detection, edge select bit one picks the falling edge
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_wake
            assign wake_edge_hit[gi] = cfg_reg[rcs_pkg::CFG_WAKE_EDGE][gi]
                ? (pins_prev_reg[gi] && !wake_pins[gi])
                : (!pins_prev_reg[gi] && wake_pins[gi]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_prev_reg <= rcs_pkg::BYTE_ZERO;
        end
        else
        begin
            pins_prev_reg <= wake_pins;
        end
    end

    // pending bits: write one to clear, a new edge wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_pending_reg <= rcs_pkg::BYTE_ZERO;
        end
        else if (wr_fire && idx == rcs_pkg::IDX_WAKE_PEND)
        begin
            wake_pending_reg <= (wake_pending_reg & ~pwdata[7:0]) | wake_edge_hit;
        end
        else
        begin
            wake_pending_reg <= wake_pending_reg | wake_edge_hit;
        end
    end

    // interrupt status, sticky per reset source
    always_comb
    begin
        int_events = rcs_pkg::BYTE_ZERO;
        int_events[rcs_pkg::INT_BOR] = soft_rst && cause == rcs_pkg::RCS_BOR;
        int_events[rcs_pkg::INT_WDT] = soft_rst && cause == rcs_pkg::RCS_WDT;
        int_events[rcs_pkg::INT_EXT] = soft_rst && cause == rcs_pkg::RCS_EXT;
        int_events[rcs_pkg::INT_WAKE] = soft_rst && cause == rcs_pkg::RCS_WAKE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_status_reg <= rcs_pkg::INT_RESET;
        end
        else if (wr_fire && idx == rcs_pkg::IDX_INT_STATUS)
        begin
            int_status_reg <= (int_status_reg & ~pwdata[7:0]) | int_events;
        end
        else
        begin
            int_status_reg <= int_status_reg | int_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_mask_reg <= rcs_pkg::BYTE_ZERO;
        end
        else if (wr_fire && idx == rcs_pkg::IDX_INT_MASK)
        begin
            int_mask_reg <= pwdata[7:0];
        end
    end

    // irq lags the status bit by one cycle to stay a flop output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(int_status_reg & int_mask_reg);
        end
    end

    // read mux
    always_comb
    begin
        rd_data = rcs_pkg::APB_ZERO;
        rd_hit = 1'b1;
        case (idx)
            rcs_pkg::IDX_COUNTER: rd_data[7:0] = counter_reg;
            rcs_pkg::IDX_PC_LOW: rd_data[7:0] = pc_low_reg;
            rcs_pkg::IDX_STATUS: rd_data[7:0] = status_reg;
            rcs_pkg::IDX_POINTER: rd_data[7:0] = pointer_reg;
            rcs_pkg::IDX_COMPARATOR: rd_data[7:0] = cmp_reg;
            rcs_pkg::IDX_WAKE_PEND: rd_data[7:0] = wake_pending_reg;
            rcs_pkg::IDX_WORKING: rd_data[7:0] = working_reg;
            rcs_pkg::IDX_PORT_DATA: rd_data[7:0] = port_data_reg;
            rcs_pkg::IDX_INT_STATUS: rd_data[7:0] = int_status_reg;
            rcs_pkg::IDX_INT_MASK: rd_data[7:0] = int_mask_reg;
            rcs_pkg::IDX_CAUSE: rd_data[4:0] = cause_reg;
            default:
                if (idx >= rcs_pkg::IDX_CFG_BASE
                    && idx < rcs_pkg::IDX_CFG_BASE + 5'(rcs_pkg::CFG_COUNT))
                begin
                    rd_data[7:0] = cfg_reg[3'(idx - rcs_pkg::IDX_CFG_BASE)];
                end
                else
                begin
                    rd_hit = 1'b0;
                end
        endcase
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign core_reset_pulse = core_reset_reg;
    assign pc_start = pc_start_reg;
    assign timeout_flag = status_reg.timeout_flag;
    assign powerdown_flag = status_reg.powerdown_flag;
    assign irq = irq_reg;
endmodule

`default_nettype wire

/* hdl/rcs_pkg.sv */
// constants, register map and carrier types for the reset cause block
// assumes a 32-bit apb bus with one register per aligned word
package rcs_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam logic [4:0] IDX_COUNTER = 5'h01;
    localparam logic [4:0] IDX_PC_LOW = 5'h02;
    localparam logic [4:0] IDX_STATUS = 5'h03;
    localparam logic [4:0] IDX_POINTER = 5'h04;
    localparam logic [4:0] IDX_CFG_BASE = 5'h05;
    localparam logic [4:0] IDX_COMPARATOR = 5'h0D;
    localparam logic [4:0] IDX_WAKE_PEND = 5'h0E;
    localparam logic [4:0] IDX_WORKING = 5'h0F;
    localparam logic [4:0] IDX_PORT_DATA = 5'h10;
    localparam logic [4:0] IDX_INT_STATUS = 5'h11;
    localparam logic [4:0] IDX_INT_MASK = 5'h12;
    localparam logic [4:0] IDX_CAUSE = 5'h13;
    localparam int CFG_COUNT = 8;
    localparam int CFG_MODE = 1;
    localparam int CFG_WAKE_EDGE = 3;
    localparam int CFG_WAKE_MASK = 4;
    localparam logic [7:0] CFG_RESET = 8'hFF;
    localparam logic [7:0] MODE_RESET = 8'h0F;
    localparam logic [7:0] PC_LOW_RESET = 8'hFF;
    localparam logic [10:0] PC_TOP = 11'h7FF;
    localparam logic [7:0] CMP_FORCE = 8'hC1;
    localparam logic [7:0] POINTER_FORCE = 8'h80;
    localparam logic [7:0] INT_RESET = 8'h01;
    localparam int INT_BOR = 0;
    localparam int INT_WDT = 1;
    localparam int INT_EXT = 2;
    localparam int INT_WAKE = 3;
    localparam logic [31:0] APB_ZERO = 32'h0000_0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [2:0] PAGE_RESET = 3'h0;

    typedef struct packed {
        logic [2:0] page;
        logic timeout_flag;
        logic powerdown_flag;
        logic [2:0] arith;
    } rcs_status_s;

    typedef enum logic [4:0] {
        RCS_POR = 5'b00001,
        RCS_BOR = 5'b00010,
        RCS_WDT = 5'b00100,
        RCS_EXT = 5'b01000,
        RCS_WAKE = 5'b10000
    } rcs_cause_e;
endpackage

/* hdl/rcs_unused_guard.sv */
// holds no logic; the whole block lives in rcs_reset_cause.sv

/* verif/rcs_reset_cause_checker.sv */
// assertions on the reset cause block ports
// assumes the apb master waits for pready and holds pin high at reset
`timescale 1ns/1ps
`default_nettype none
module rcs_checker
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // events and results
    input wire logic brownout_event,
    input wire logic watchdog_expire,
    input wire logic external_reset_pin_n,
    input wire logic core_sleep,
    input wire logic core_reset_pulse,
    input wire logic [10:0] pc_start,
    input wire logic timeout_flag,
    input wire logic powerdown_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_pin_fall;
        $fell(external_reset_pin_n) && !brownout_event;
    endsequence
    sequence s_wdt_only;
        watchdog_expire && !brownout_event && !$fell(external_reset_pin_n);
    endsequence
    sequence s_quiet;
        !brownout_event && !watchdog_expire && external_reset_pin_n && !core_sleep;
    endsequence
    a_pc_top: assert property (pc_start == 11'h7FF)
        else $error("pc start not at top address");
    a_wdt_run_flags: assert property (s_wdt_only ##0 !core_sleep |=> !timeout_flag && powerdown_flag)
        else $error("watchdog while running gave wrong flags");
    a_wdt_sleep_flags: assert property (s_wdt_only ##0 core_sleep |=> !timeout_flag && !powerdown_flag)
        else $error("watchdog in power-down gave wrong flags");
    a_pin_run_flags: assert property (s_pin_fall ##0 !core_sleep |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("pin reset while running changed flags");
    a_pin_sleep_flags: assert property (s_pin_fall ##0 core_sleep |=> timeout_flag && !powerdown_flag)
        else $error("pin reset in power-down gave wrong flags");
    a_flags_hold: assert property (s_quiet |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("flags moved without an event");
    a_redirect_pulse: assert property ((brownout_event || watchdog_expire) |=> core_reset_pulse)
        else $error("no core reset pulse after event");
    a_pulse_quiet: assert property (s_quiet |=> !core_reset_pulse)
        else $error("core reset pulse without event");
    a_apb_answer: assert property (s_setup |-> ##2 pready)
        else $error("apb answer late");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
endmodule

bind rcs_reset_cause rcs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .brownout_event(brownout_event),
    .watchdog_expire(watchdog_expire), .external_reset_pin_n(external_reset_pin_n),
    .core_sleep(core_sleep), .core_reset_pulse(core_reset_pulse), .pc_start(pc_start),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
`default_nettype wire

/* verif/test_rcs_reset_cause.sv */
// self-checking bench for the reset cause block
// assumes the checker file is compiled beside it
`timescale 1ns/1ps
`default_nettype none
module test_rcs_reset_cause;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic brownout_event = 1'b0;
    logic watchdog_expire = 1'b0;
    logic pin_n = 1'b1;
    logic core_sleep = 1'b0;
    logic [7:0] wake_pins = 8'h00;
    logic core_reset_pulse;
    logic [10:0] pc_start;
    logic timeout_flag;
    logic powerdown_flag;
    logic irq;
    logic [31:0] rdata;
    logic rerr;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    always #12.5 pclk = ~pclk;

    rcs_reset_cause dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .brownout_event(brownout_event), .watchdog_expire(watchdog_expire),
        .external_reset_pin_n(pin_n), .core_sleep(core_sleep), .wake_pins(wake_pins),
        .core_reset_pulse(core_reset_pulse), .pc_start(pc_start),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; read data and error taken at the pready edge
    // no wait limit here: a hung slave is caught by the bench timeout
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        apb(1'b1, {1'b0, idx, 2'b00}, {24'h000000, d});
    endtask

    task automatic rd(input string what, input logic [4:0] idx, input logic [7:0] exp);
        apb(1'b0, {1'b0, idx, 2'b00}, 32'h0000_0000);
        chk(what, rdata, {24'h000000, exp});
    endtask

    // which: 0 brown-out, 1 watchdog
    task automatic pulse(input int which);
        @(posedge pclk);
        if (which == 0)
            brownout_event <= 1'b1;
        else
            watchdog_expire <= 1'b1;
        @(posedge pclk);
        brownout_event <= 1'b0;
        watchdog_expire <= 1'b0;
        @(posedge pclk);
        chk("reset pulse", core_reset_pulse, 1'b1);
    endtask

    task automatic pin_fall();
        @(posedge pclk);
        pin_n <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        pin_n <= 1'b1;
    endtask

    task automatic t_reset();
        chk("flags", {timeout_flag, powerdown_flag}, 2'b11);
        chk("pc start", pc_start, 11'h7FF);
        rd("status", rcs_pkg::IDX_STATUS, 8'h18);
        rd("pc low", rcs_pkg::IDX_PC_LOW, 8'hFF);
        for (int i = 0; i < rcs_pkg::CFG_COUNT; i++)
            rd("cfg", 5'(rcs_pkg::IDX_CFG_BASE + i), (i == rcs_pkg::CFG_MODE) ? 8'h0F : 8'hFF);
    endtask

    task automatic t_watchdog();
        wr(rcs_pkg::IDX_CFG_BASE, 8'h00);
        wr(rcs_pkg::IDX_STATUS, 8'hA5);
        rd("status write", rcs_pkg::IDX_STATUS, 8'hBD);
        wr(rcs_pkg::IDX_WORKING, 8'h5A);
        pulse(1);
        chk("flags", {timeout_flag, powerdown_flag}, 2'b01);
        rd("options", rcs_pkg::IDX_CFG_BASE, 8'hFF);
        rd("status", rcs_pkg::IDX_STATUS, 8'h0D);
        rd("working", rcs_pkg::IDX_WORKING, 8'h5A);
        rd("pc low", rcs_pkg::IDX_PC_LOW, 8'hFF);
    endtask

    task automatic t_pin();
        pin_fall();
        chk("flags", {timeout_flag, powerdown_flag}, 2'b01);
        rd("working", rcs_pkg::IDX_WORKING, 8'h5A);
        @(posedge pclk);
        core_sleep <= 1'b1;
        pin_fall();
        chk("flags", {timeout_flag, powerdown_flag}, 2'b10);
        pulse(1);
        chk("flags", {timeout_flag, powerdown_flag}, 2'b00);
        core_sleep <= 1'b0;
    endtask

    task automatic t_wake();
        wr(5'(rcs_pkg::IDX_CFG_BASE + rcs_pkg::CFG_WAKE_EDGE), 8'h00);
        wr(5'(rcs_pkg::IDX_CFG_BASE + rcs_pkg::CFG_WAKE_MASK), 8'hFE);
        @(posedge pclk);
        wake_pins <= 8'h01;
        rd("pending", rcs_pkg::IDX_WAKE_PEND, 8'h01);
        wake_pins <= 8'h00;
        rd("pending held", rcs_pkg::IDX_WAKE_PEND, 8'h01);
        @(posedge pclk);
        core_sleep <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        core_sleep <= 1'b0;
        chk("flags", {timeout_flag, powerdown_flag}, 2'b10);
        rd("pending kept", rcs_pkg::IDX_WAKE_PEND, 8'h01);
        wr(rcs_pkg::IDX_WAKE_PEND, 8'h01);
        rd("pending clear", rcs_pkg::IDX_WAKE_PEND, 8'h00);
    endtask

    task automatic t_irq();
        wr(rcs_pkg::IDX_INT_STATUS, 8'h0F);
        rd("int status", rcs_pkg::IDX_INT_STATUS, 8'h00);
        wr(rcs_pkg::IDX_INT_MASK, 8'h02);
        pulse(1);
        @(posedge pclk);
        chk("irq", irq, 1'b1);
        wr(rcs_pkg::IDX_INT_MASK, 8'h00);
        @(posedge pclk);
        @(posedge pclk);
        chk("irq masked", irq, 1'b0);
        wr(rcs_pkg::IDX_INT_MASK, 8'h02);
        wr(rcs_pkg::IDX_INT_STATUS, 8'h02);
        @(posedge pclk);
        @(posedge pclk);
        chk("irq cleared", irq, 1'b0);
    endtask

    task automatic t_other();
        pulse(0);
        chk("pc start", pc_start, 11'h7FF);
        rd("mode", 5'(rcs_pkg::IDX_CFG_BASE + rcs_pkg::CFG_MODE), 8'h0F);
        apb(1'b0, 8'h7C, 32'h0000_0000);
        chk("unmapped err", rerr, 1'b1);
        chk("unmapped data", rdata, 32'h0000_0000);
        apb(1'b1, 8'h15, 32'h0000_0000);
        chk("unaligned err", rerr, 1'b1);
        rd("options kept", rcs_pkg::IDX_CFG_BASE, 8'hFF);
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_watchdog();
        t_pin();
        t_wake();
        t_irq();
        t_other();
        wrap_up();
    end
endmodule
`default_nettype wire
